// file: logic/tlfm_monitor.sv
`include "tlfm_map.svh"

// What this block does
// - feed-unit tray 3: lift sensor not on 10 s after lift, fault 503-1
// - capacity tray 3: lift sensor no change within 8 s, fault 503-1
// - feed-unit tray 3: lift sensor not off 1.5 s after lowering, failure
// - capacity tray at power-on or tray insert, fence out of home stops lift motor
// - capacity tray: upper limit not released 1.5 s into lowering, failure
// - tray 3 lowering or fence failure three times running gives 503-2
// - tray 4: upper limit not seen 10 s after lift, failure
// - tray 4 lift failure three times running gives 504-2
// - tray 5: lift sensor not on after raising, fault 505-1
// - tray 5: lift sensor not off after lowering, fault 505-1
// - tray 5 at power-on: sensor not on after solenoid, fault 505-1
// - tray 5 lift and lower limit both on at power or door, 505-2
// - fusing exhaust fan no lock within 10 s, fault 530
// - exhaust fan motor no lock within 10 s, fault 531
// - cooling fan motor no lock within 10 s, fault 532
// - paper exit cooling fan no lock within 10 s, fault 533
// - fusing motor no lock within 2 s, fault 540
module tlfm_monitor #(
   parameter int TICK_CYC = `TLFM_TICK_CYC,
   parameter int T5_TIMEOUT_DS = `TLFM_T_T5_DS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cap_tray_sel,
   input wire logic cap_tray_inserted,
   input wire logic right_door_closed,
   input wire tlfm_pkg::tlfm_drive_t drive,
   input wire tlfm_pkg::tlfm_sense_t sense_pin,
   output logic t3_lift_stop,
   output tlfm_pkg::tlfm_fault_t service_fault_code
);
   import tlfm_pkg::*;

   localparam int NT = 12;
   localparam logic [7:0] LIM_10S = 8'(`TLFM_T_10S_DS);
   localparam logic [7:0] LIM_8S = 8'(`TLFM_T_8S_DS);
   localparam logic [7:0] LIM_1P5 = 8'(`TLFM_T_1P5S_DS);
   localparam logic [7:0] LIM_2S = 8'(`TLFM_T_2S_DS);
   localparam logic [7:0] LIM_T5 = 8'(T5_TIMEOUT_DS);
   localparam logic [1:0] FAIL_LIM = 2'(`TLFM_FAIL_LIMIT);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [12:0] meta_q;
   logic [12:0] sync_q;
   tlfm_sense_t sense;
   logic cap_ins_s;
   logic door_s;

   // pins are asynchronous; the first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 13'h0;
         sync_q <= 13'h0;
      end else begin
         meta_q <= {right_door_closed, cap_tray_inserted, sense_pin};
         sync_q <= meta_q;
      end
   end
   assign sense = sync_q[10:0];
   assign cap_ins_s = sync_q[11];
   assign door_s = sync_q[12];

   // ************************************************************
   // tenth-of-a-second timebase
   // ************************************************************
   logic [31:0] pre_q;
   logic tick;
   assign tick = (pre_q == 32'(TICK_CYC - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 32'h0;
      end else if (tick) begin
         pre_q <= 32'h0;
      end else begin
         pre_q <= pre_q + 32'h1;
      end
   end

   // ************************************************************
   // supervision timers
   // ************************************************************
   // index: 0 t3 lift, 1 t3 lower, 2 t4 lift, 3 t5 lift, 4 t5 lower,
   // 5 t5 solenoid, 6 fuse exh fan, 7 exh fan, 8 cool fan,
   // 9 exit fan, 10 fuse motor, 11 capacity tray 3 lower (sensor change)
   logic [NT-1:0] en;
   logic [NT-1:0] en_prev_q;
   logic [NT-1:0] resp;
   logic [NT-1:0] armed_q;
   logic [NT-1:0] expire;
   logic [7:0] cnt_q [NT];
   logic [7:0] lim [NT];
   logic t3_lift_start_hi_q;
   logic t3_lower_start_hi_q;
   logic t5_power_on_q;

   assign en = {drive.t3_lower_on & cap_tray_sel,
                drive.fuse_motor_on, drive.exit_fan_on, drive.cool_fan_on,
                drive.exh_fan_on, drive.fuse_exh_fan_on,
                drive.t5_solenoid_on & t5_power_on_q, drive.t5_lower_on,
                drive.t5_lift_on, drive.t4_lift_on, drive.t3_lower_on,
                drive.t3_lift_on};

   // expected answers; capacity tray watches for any change of sensor
   always_comb begin
      resp[0] = cap_tray_sel ? (sense.t3_lift_sensor != t3_lift_start_hi_q)
                             : sense.t3_lift_sensor;
      resp[1] = cap_tray_sel ? !sense.t3_upper_limit
                             : !sense.t3_lift_sensor;
      resp[2] = sense.t4_upper_limit;
      resp[3] = sense.t5_lift_sensor;
      resp[4] = !sense.t5_lift_sensor;
      resp[5] = sense.t5_lift_sensor;
      resp[6] = sense.fuse_exh_fan_lock;
      resp[7] = sense.exh_fan_lock;
      resp[8] = sense.cool_fan_lock;
      resp[9] = sense.exit_fan_lock;
      resp[10] = sense.fuse_motor_lock;
      resp[11] = sense.t3_lift_sensor != t3_lower_start_hi_q;
   end

   // time limits per channel
   always_comb begin
      lim[0] = cap_tray_sel ? LIM_8S : LIM_10S;
      lim[1] = LIM_1P5;
      lim[2] = LIM_10S;
      lim[3] = LIM_T5;
      lim[4] = LIM_T5;
      lim[5] = LIM_T5;
      lim[6] = LIM_10S;
      lim[7] = LIM_10S;
      lim[8] = LIM_10S;
      lim[9] = LIM_10S;
      lim[10] = LIM_2S;
      lim[11] = LIM_8S;
   end

   // capacity tray lift: remember sensor level at motor start
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t3_lift_start_hi_q <= 1'b0;
      end else if (en[0] && !en_prev_q[0]) begin
         t3_lift_start_hi_q <= sense.t3_lift_sensor;
      end
   end

   // capacity tray lowering: same change watch from the level at start
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t3_lower_start_hi_q <= 1'b0;
      end else if (en[11] && !en_prev_q[11]) begin
         t3_lower_start_hi_q <= sense.t3_lift_sensor;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_prev_q <= '0;
      end else begin
         en_prev_q <= en;
      end
   end

   // one timer per channel; a rise always restarts, even mid-count
   for (genvar i = 0; i < NT; i++) begin : g_tmr
      assign expire[i] = armed_q[i] && en[i] && (cnt_q[i] >= lim[i]);
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            armed_q[i] <= 1'b0;
            cnt_q[i] <= 8'h0;
         end else if (en[i] && !en_prev_q[i]) begin
            armed_q[i] <= 1'b1;
            cnt_q[i] <= 8'h0;
         end else if (!en[i] || resp[i] || expire[i]) begin
            armed_q[i] <= 1'b0;
         end else if (armed_q[i] && tick) begin
            cnt_q[i] <= cnt_q[i] + 8'h1;
         end
      end
   end

   // a good answer ends an attempt successfully
   logic [NT-1:0] success;
   assign success = armed_q & en & resp & ~(en & ~en_prev_q);

   // ************************************************************
   // power-on and insertion events
   // ************************************************************
   logic por_q;
   logic cap_ins_prev_q;
   logic door_prev_q;
   logic cap_ins_rise;
   logic door_rise;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         por_q <= 1'b1;
         cap_ins_prev_q <= 1'b0;
         door_prev_q <= 1'b0;
      end else begin
         if (tick) begin
            por_q <= 1'b0;
         end
         cap_ins_prev_q <= cap_ins_s;
         door_prev_q <= door_s;
      end
   end
   assign cap_ins_rise = cap_ins_s && !cap_ins_prev_q;
   assign door_rise = door_s && !door_prev_q;

   // solenoid check is a power-on only sequence; ends on first release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t5_power_on_q <= 1'b1;
      end else if (en_prev_q[5] && !drive.t5_solenoid_on) begin
         t5_power_on_q <= 1'b0;
      end
   end

   // fence check: capacity tray fence out at power-on or insertion stops the lift
   logic fence_fail;
   logic fence_fail_q;
   logic fence_evt;
   assign fence_fail = cap_tray_sel && sense.t3_fence_home &&
                       (por_q || cap_ins_rise);

   // one attempt per power-on or insertion; the power-on window spans
   // many cycles and must not count as several attempts
   assign fence_evt = fence_fail && !fence_fail_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fence_fail_q <= 1'b0;
      end else begin
         fence_fail_q <= fence_fail;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t3_lift_stop <= 1'b0;
      end else if (fence_fail) begin
         t3_lift_stop <= 1'b1;
      end else if (cap_tray_sel && !sense.t3_fence_home) begin
         t3_lift_stop <= 1'b0;
      end
   end

   // upper limit must have been seen at power-on before lowering check
   logic ul_seen_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ul_seen_q <= 1'b0;
      end else if (por_q && sense.t3_upper_limit) begin
         ul_seen_q <= 1'b1;
      end
   end

   // ************************************************************
   // consecutive failure counting
   // ************************************************************
   logic t3_low_fail;
   logic t3_low_ok;
   logic [1:0] t3_fails_q;
   logic [1:0] t4_fails_q;
   logic fire_503_2;
   logic fire_504_2;

   assign t3_low_fail = (expire[1] && (!cap_tray_sel || ul_seen_q)) ||
                        fence_evt;
   assign t3_low_ok = success[1];
   assign fire_503_2 = t3_low_fail && (t3_fails_q == FAIL_LIM - 2'h1);
   assign fire_504_2 = expire[2] && (t4_fails_q == FAIL_LIM - 2'h1);

   // failure wins over a same-cycle success; success clears the run
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t3_fails_q <= 2'h0;
      end else if (t3_low_fail) begin
         t3_fails_q <= fire_503_2 ? t3_fails_q : t3_fails_q + 2'h1;
      end else if (t3_low_ok) begin
         t3_fails_q <= 2'h0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t4_fails_q <= 2'h0;
      end else if (expire[2]) begin
         t4_fails_q <= fire_504_2 ? t4_fails_q : t4_fails_q + 2'h1;
      end else if (success[2]) begin
         t4_fails_q <= 2'h0;
      end
   end

   // ************************************************************
   // fault selection and latch
   // ************************************************************
   logic fire_505_2;
   assign fire_505_2 = sense.t5_lift_sensor && sense.t5_lower_limit &&
                       (por_q || door_rise);

   logic hit;
   logic [9:0] hit_code;
   logic [1:0] hit_sub;

   // fixed priority when several faults land in the same cycle
   always_comb begin
      hit = 1'b1;
      hit_code = 10'h0;
      hit_sub = 2'h0;
      if (expire[0] || expire[11]) begin
         hit_code = `TLFM_CODE_503;
         hit_sub = 2'h1;
      end else if (fire_503_2) begin
         hit_code = `TLFM_CODE_503;
         hit_sub = 2'h2;
      end else if (fire_504_2) begin
         hit_code = `TLFM_CODE_504;
         hit_sub = 2'h2;
      end else if (expire[3] || expire[4] || expire[5]) begin
         hit_code = `TLFM_CODE_505;
         hit_sub = 2'h1;
      end else if (fire_505_2) begin
         hit_code = `TLFM_CODE_505;
         hit_sub = 2'h2;
      end else if (expire[6]) begin
         hit_code = `TLFM_CODE_530;
      end else if (expire[7]) begin
         hit_code = `TLFM_CODE_531;
      end else if (expire[8]) begin
         hit_code = `TLFM_CODE_532;
      end else if (expire[9]) begin
         hit_code = `TLFM_CODE_533;
      end else if (expire[10]) begin
         hit_code = `TLFM_CODE_540;
      end else begin
         hit = 1'b0;
      end
   end

   // first fault holds until reset so the cause is never overwritten
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         service_fault_code <= '0;
      end else if (hit && !service_fault_code.valid) begin
         service_fault_code <= '{valid: 1'b1, code: hit_code,
                                 sub: hit_sub};
      end
   end
endmodule

// file: logic/tlfm_map.svh
`ifndef TLFM_MAP_SVH
`define TLFM_MAP_SVH
// ************************************************************
// timebase and supervision times
// ************************************************************
`define TLFM_CLK_HZ 50000000
`define TLFM_TICKS_PER_SEC 10
`define TLFM_TICK_CYC (`TLFM_CLK_HZ / `TLFM_TICKS_PER_SEC)
`define TLFM_T_10S_DS 100
`define TLFM_T_8S_DS 80
`define TLFM_T_1P5S_DS 15
`define TLFM_T_2S_DS 20
`define TLFM_T_T5_DS 100
`define TLFM_FAIL_LIMIT 3
// ************************************************************
// fault codes
// ************************************************************
`define TLFM_CODE_503 10'h1f7
`define TLFM_CODE_504 10'h1f8
`define TLFM_CODE_505 10'h1f9
`define TLFM_CODE_530 10'h212
`define TLFM_CODE_531 10'h213
`define TLFM_CODE_532 10'h214
`define TLFM_CODE_533 10'h215
`define TLFM_CODE_540 10'h21c
`endif

// file: logic/tlfm_pkg.sv
package tlfm_pkg;
   // motor / solenoid enables seen by the monitor
   typedef struct packed {
      logic fuse_motor_on;
      logic exit_fan_on;
      logic cool_fan_on;
      logic exh_fan_on;
      logic fuse_exh_fan_on;
      logic t5_solenoid_on;
      logic t5_lower_on;
      logic t5_lift_on;
      logic t4_lift_on;
      logic t3_lower_on;
      logic t3_lift_on;
   } tlfm_drive_t;
   // sensor and lock inputs (asynchronous pins)
   typedef struct packed {
      logic fuse_motor_lock;
      logic exit_fan_lock;
      logic cool_fan_lock;
      logic exh_fan_lock;
      logic fuse_exh_fan_lock;
      logic t5_lower_limit;
      logic t5_lift_sensor;
      logic t4_upper_limit;
      logic t3_fence_home;
      logic t3_upper_limit;
      logic t3_lift_sensor;
   } tlfm_sense_t;
   typedef struct packed {
      logic valid;
      logic [9:0] code;
      logic [1:0] sub;
   } tlfm_fault_t;
endpackage

// file: tb/tlfm_chk_monitor.sv
`include "tlfm_map.svh"
// ************************************************************
// port checker for the fault monitor
// ************************************************************
module tlfm_chk_monitor #(
   parameter int TICK_CYC = `TLFM_TICK_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cap_tray_sel,
   input wire logic cap_tray_inserted,
   input wire logic right_door_closed,
   input wire tlfm_pkg::tlfm_drive_t drive,
   input wire tlfm_pkg::tlfm_sense_t sense_pin,
   input wire logic t3_lift_stop,
   input wire tlfm_pkg::tlfm_fault_t service_fault_code
);
   import tlfm_pkg::*;
   // one tick of slack each way for the partial first tick
   localparam int FM_LATE = 21 * TICK_CYC + 4;
   localparam int FM_EARLY = 19 * TICK_CYC - 2;
   localparam int XF_LATE = 101 * TICK_CYC + 4;
   tlfm_drive_t drv_q;
   logic [31:0] fm_q;
   logic [31:0] xf_q;
   wire tlfm_fault_t f = service_fault_code;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // previous enables, to find each rise
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) drv_q <= '0;
      else drv_q <= drive;
   end
   // cycles since fusing motor rise, zero once a lock is seen
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) fm_q <= '0;
      else if (drive.fuse_motor_on && !drv_q.fuse_motor_on) fm_q <= 32'h1;
      else if (fm_q != '0 && drive.fuse_motor_on &&
         !sense_pin.fuse_motor_lock) fm_q <= fm_q + 32'h1;
      else fm_q <= '0;
   end
   // same count for the fusing exhaust fan
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) xf_q <= '0;
      else if (drive.fuse_exh_fan_on && !drv_q.fuse_exh_fan_on) xf_q <= 32'h1;
      else if (xf_q != '0 && drive.fuse_exh_fan_on &&
         !sense_pin.fuse_exh_fan_lock) xf_q <= xf_q + 32'h1;
      else xf_q <= '0;
   end
   AST_VALID_STICKY: assert property (f.valid |=> f.valid)
      else $error("fault flag dropped");
   AST_CODE_HELD: assert property (f.valid |=> $stable({f.code, f.sub}))
      else $error("latched fault changed");
   AST_SUB_KIND: assert property (f.valid |->
      ((f.code >= `TLFM_CODE_503 && f.code <= `TLFM_CODE_505) == (f.sub != 2'h0)))
      else $error("sub code does not suit main code");
   AST_540_LATE: assert property (fm_q == FM_LATE |-> f.valid)
      else $error("fusing motor fault missing");
   AST_540_EARLY: assert property (
      ($rose(f.valid) && f.code == `TLFM_CODE_540) |-> fm_q >= FM_EARLY)
      else $error("fusing motor fault too early");
   AST_530_LATE: assert property (xf_q == XF_LATE |-> f.valid)
      else $error("exhaust fan fault missing");
   AST_STOP_CLEAR: assert property (
      !sense_pin.t3_fence_home [*3] |=> !t3_lift_stop)
      else $error("lift stop kept with fence home");
   AST_STOP_CAUSE: assert property ($rose(t3_lift_stop) |-> $past(cap_tray_sel))
      else $error("lift stop without capacity tray");
   cover property ($rose(f.valid) && f.code == `TLFM_CODE_540);
   cover property ($rose(f.valid) && f.sub == 2'h2);
   cover property ($rose(t3_lift_stop));
endmodule
bind tlfm_monitor tlfm_chk_monitor #(.TICK_CYC(TICK_CYC)) i_tlfm_chk_monitor (
   .clock(clock), .rst_n(rst_n), .cap_tray_sel(cap_tray_sel),
   .cap_tray_inserted(cap_tray_inserted),
   .right_door_closed(right_door_closed), .drive(drive),
   .sense_pin(sense_pin), .t3_lift_stop(t3_lift_stop),
   .service_fault_code(service_fault_code));

// file: tb/tlfm_plant.sv
// ************************************************************
// motors, fans and sensors on the far side
// ************************************************************
module tlfm_plant (
   input wire logic clock,
   input wire logic rst_n,
   input wire tlfm_pkg::tlfm_drive_t drive,
   input wire tlfm_pkg::tlfm_sense_t brk,
   input wire tlfm_pkg::tlfm_sense_t frc,
   output tlfm_pkg::tlfm_sense_t sense_pin
);
   import tlfm_pkg::*;
   logic t3_q, t4_q, t5_q;
   tlfm_sense_t resp, p1_q, p2_q, p3_q;
   // tray positions follow their motors
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         t3_q <= 1'b0;
         t4_q <= 1'b0;
         t5_q <= 1'b0;
      end else begin
         if (drive.t3_lift_on) t3_q <= 1'b1;
         else if (drive.t3_lower_on) t3_q <= 1'b0;
         if (drive.t4_lift_on) t4_q <= 1'b1;
         if (drive.t5_lift_on || drive.t5_solenoid_on) t5_q <= 1'b1;
         else if (drive.t5_lower_on) t5_q <= 1'b0;
      end
   end
   // running fans report lock; fence and lower limit rest off
   assign resp = {drive.fuse_motor_on, drive.exit_fan_on, drive.cool_fan_on,
      drive.exh_fan_on, drive.fuse_exh_fan_on, 1'b0, t5_q, t4_q, 1'b0,
      t3_q, t3_q};
   // mechanical lag, so no answer lands in the enable's own cycle
   always_ff @(posedge clock) begin
      p1_q <= resp;
      p2_q <= p1_q;
      p3_q <= p2_q;
   end
   // a broken part shows the bench's stuck level instead
   assign sense_pin = (p3_q & ~brk) | (frc & brk);
endmodule

// file: tb/tlfm_tb_top.sv
`include "tlfm_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tlfm_pkg::*;
   // ************************************************************
   // bench with a short tick so the long timeouts stay cheap
   // ************************************************************
   localparam int TK = 10;
   localparam int T5 = 20;
   logic clock = 1'b0, rst_n = 1'b0, cap_tray_sel = 1'b0;
   logic cap_tray_inserted = 1'b0, right_door_closed = 1'b0, t3_lift_stop;
   tlfm_drive_t drive = '0;
   tlfm_sense_t brk = '0, frc = '0, sense_pin;
   tlfm_fault_t sf;
   int fail_count = 0, n_compared = 0, cyc = 0;
   tlfm_monitor #(.TICK_CYC(TK), .T5_TIMEOUT_DS(T5)) i_tlfm_monitor (
      .clock(clock), .rst_n(rst_n), .cap_tray_sel(cap_tray_sel),
      .cap_tray_inserted(cap_tray_inserted),
      .right_door_closed(right_door_closed), .drive(drive),
      .sense_pin(sense_pin), .t3_lift_stop(t3_lift_stop),
      .service_fault_code(sf));
   tlfm_plant i_tlfm_plant (.clock(clock), .rst_n(rst_n), .drive(drive),
      .brk(brk), .frc(frc), .sense_pin(sense_pin));
   // 50 MHz clock
   always #10 clock = ~clock;
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic ticks(input int n);
      step(n * TK);
   endtask
   task automatic restart();
      rst_n = 1'b0;
      drive = '0;
      brk = '0;
      frc = '0;
      cap_tray_sel = 1'b0;
      right_door_closed = 1'b0;
      step(6);
      rst_n = 1'b1;
   endtask
   task automatic expect_f(input logic v, input logic [9:0] c,
      input logic [1:0] s, input string m);
      n_compared++;
      if (sf.valid !== v || (v && (sf.code !== c || sf.sub !== s))) begin
         fail_count++;
         $display("wrong value at %0t: fault %s", $time, m);
      end
   endtask
   task automatic expect_stop(input logic v, input string m);
      n_compared++;
      if (t3_lift_stop !== v) begin
         fail_count++;
         $display("wrong value at %0t: lift stop %s", $time, m);
      end
   endtask
   // lock works, then drop and restart mid-count, then no lock
   task automatic t_lock(input int b, input logic [9:0] c, input int lim);
      restart();
      drive[b] = 1'b1;
      ticks(lim + 5);
      expect_f(1'b0, c, 2'h0, "with lock");
      drive[b] = 1'b0;
      brk[b] = 1'b1;
      step(1);
      drive[b] = 1'b1;
      ticks(lim - 5);
      drive[b] = 1'b0;
      step(1);
      drive[b] = 1'b1;
      ticks(lim - 3);
      expect_f(1'b0, c, 2'h0, "early");
      ticks(5);
      expect_f(1'b1, c, 2'h0, "lock missing");
      $display("lock test %0d done", c);
   endtask
   // tray 3 lift sensor stuck off while drive bit b moves the tray
   task automatic t_t3_lift(input int b, input logic cap, input int lim);
      restart();
      cap_tray_sel = cap;
      brk[0] = 1'b1;
      drive[b] = 1'b1;
      ticks(lim - 3);
      expect_f(1'b0, `TLFM_CODE_503, 2'h1, "t3 early");
      ticks(5);
      expect_f(1'b1, `TLFM_CODE_503, 2'h1, "t3 lift");
      $display("t3 lift test done");
   endtask
   // lowering fails, fails, works, then fails three times running
   task automatic t_t3_lower();
      restart();
      drive.t3_lift_on = 1'b1;
      step(2);
      drive.t3_lift_on = 1'b0;
      frc[0] = 1'b1;
      for (int i = 0; i < 6; i++) begin
         brk[0] = (i != 2);
         step(2);
         drive.t3_lower_on = 1'b1;
         ticks(17);
         drive.t3_lower_on = 1'b0;
         step(2);
         expect_f(i == 5, `TLFM_CODE_503, 2'h2, "t3 lower");
      end
      $display("t3 lower test done");
   endtask
   // capacity tray: upper limit seen at power-on, then stuck on lowering
   task automatic t_t3_cap_lower();
      restart();
      cap_tray_sel = 1'b1;
      brk[1] = 1'b1;
      frc[1] = 1'b1;
      for (int i = 0; i < 3; i++) begin
         step(2);
         drive.t3_lower_on = 1'b1;
         ticks(17);
         drive.t3_lower_on = 1'b0;
         expect_f(i == 2, `TLFM_CODE_503, 2'h2, "cap lower");
      end
      $display("capacity lower test done");
   endtask
   task automatic t_t4();
      restart();
      brk[3] = 1'b1;
      for (int i = 0; i < 3; i++) begin
         drive.t4_lift_on = 1'b1;
         ticks(102);
         drive.t4_lift_on = 1'b0;
         step(2);
         expect_f(i == 2, `TLFM_CODE_504, 2'h2, "t4 lift");
      end
      $display("t4 test done");
   endtask
   // tray 5 sensor stuck at lvl while drive bit b moves the tray
   task automatic t_t5(input int b, input logic lvl);
      restart();
      brk[4] = 1'b1;
      frc[4] = lvl;
      step(4);
      drive[b] = 1'b1;
      ticks(T5 - 3);
      expect_f(1'b0, `TLFM_CODE_505, 2'h1, "t5 early");
      ticks(5);
      expect_f(1'b1, `TLFM_CODE_505, 2'h1, "t5 move");
      $display("t5 test done");
   endtask
   task automatic t_t5_both();
      restart();
      ticks(2);
      brk[5:4] = 2'h3;
      frc[5:4] = 2'h3;
      step(6);
      expect_f(1'b0, `TLFM_CODE_505, 2'h2, "no door event");
      right_door_closed = 1'b1;
      step(6);
      expect_f(1'b1, `TLFM_CODE_505, 2'h2, "both sensors");
      $display("t5 both test done");
   endtask
   // fence out at power-on, then again at tray insertion
   task automatic t_fence();
      rst_n = 1'b0;
      cap_tray_sel = 1'b1;
      brk[2] = 1'b1;
      frc[2] = 1'b1;
      step(6);
      rst_n = 1'b1;
      step(6);
      expect_stop(1'b1, "power-on");
      brk[2] = 1'b0;
      ticks(2);
      expect_stop(1'b0, "fence home");
      brk[2] = 1'b1;
      cap_tray_inserted = 1'b1;
      step(6);
      expect_stop(1'b1, "insertion");
      expect_f(1'b0, `TLFM_CODE_503, 2'h2, "two fence events");
      cap_tray_inserted = 1'b0;
      brk[2] = 1'b0;
      ticks(2);
      brk[2] = 1'b1;
      cap_tray_inserted = 1'b1;
      step(6);
      expect_f(1'b1, `TLFM_CODE_503, 2'h2, "third fence event");
      cap_tray_inserted = 1'b0;
      $display("fence test done");
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         $display("wrong value at %0t: run too long", $time);
         report_and_stop();
      end
   end
   // main sequence
   initial begin
      t_fence();
      t_lock(6, `TLFM_CODE_530, 100);
      t_lock(7, `TLFM_CODE_531, 100);
      t_lock(8, `TLFM_CODE_532, 100);
      t_lock(9, `TLFM_CODE_533, 100);
      t_lock(10, `TLFM_CODE_540, 20);
      t_t3_lift(0, 1'b0, 100);
      t_t3_lift(0, 1'b1, 80);
      t_t3_lift(1, 1'b1, 80);
      t_t3_lower();
      t_t3_cap_lower();
      t_t4();
      t_t5(3, 1'b0);
      t_t5(4, 1'b1);
      t_t5(5, 1'b0);
      t_t5_both();
      report_and_stop();
   end
endmodule
